// ---- design/region_perm.sv ----
// Access permission checker for target regions 5 to 8 with Wishbone regs
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Config bits 31:16 and 15:10 hold the upper and lower base address.
// - Config bit 9 is the priority and bits 7:3 the five-bit region size.
// - Read permission bits 3:0 hold one enable per privilege group.
// - Write permission bits 3:0 hold one enable per privilege group.
// - Unimplemented bits of these registers read as zero.
// - Reset values are target-specific presets, not forced to zero.
// - A set permission bit grants the group that access, a clear one not.
// - Some permission bits may be read-only with preset values.
`include "region_perm_regs.svh"

module region_perm
   import region_perm_pkg::*;
#(
   parameter int          NUM_REGIONS  = 4,
   parameter int          FIRST_REGION = 5,
   parameter logic [31:0] CFG_PRESET   = `CFG_RESET,
   parameter logic [3:0]  RD_PRESET    = `RD_PERM_RESET,
   parameter logic [3:0]  WR_PRESET    = `WR_PERM_RESET,
   parameter logic [3:0]  RD_WR_MASK   = `PERM_WR_MASK,
   parameter logic [3:0]  WR_WR_MASK   = `PERM_WR_MASK
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [15:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_wb_err,
   // Target access check
   input  wire logic        i_acc_valid,
   input  wire logic [31:0] i_acc_phys_addr,
   input  wire logic        i_acc_write,
   input  wire logic [1:0]  i_acc_group,
   output logic             o_acc_hit,
   output logic             o_acc_grant,
   output logic             o_acc_bus_err,
   output logic [1:0]       o_acc_region
);

   // --------------------------------------------------------------------
   // Elaboration checks
   // --------------------------------------------------------------------
   generate
      if (NUM_REGIONS != 4) begin : g_bad_count
         $error("region_perm: exactly four regions are mapped");
      end
      if (FIRST_REGION != 5) begin : g_bad_first
         $error("region_perm: the map starts at region 5");
      end
      if ((CFG_PRESET & ~`CFG_IMPL_MASK) != 32'h0000_0000) begin : g_bad_cfg
         $error("region_perm: preset sets unimplemented config bits");
      end
   endgenerate

   // --------------------------------------------------------------------
   // Register decode
   // --------------------------------------------------------------------
   function automatic reg_kind_t decode_kind(input logic [15:0] adr);
      unique case (adr)
         `REG5_CFG_OFS, `REG6_CFG_OFS, `REG7_CFG_OFS, `REG8_CFG_OFS:
            decode_kind = KIND_CFG;
         `REG5_RD_OFS, `REG6_RD_OFS, `REG7_RD_OFS, `REG8_RD_OFS:
            decode_kind = KIND_RD;
         `REG5_WR_OFS, `REG6_WR_OFS, `REG7_WR_OFS, `REG8_WR_OFS:
            decode_kind = KIND_WR;
         default:
            decode_kind = KIND_NONE;
      endcase
   endfunction

   function automatic logic [1:0] decode_index(input logic [15:0] adr);
      unique case (adr)
         `REG5_CFG_OFS, `REG5_RD_OFS, `REG5_WR_OFS: decode_index = 2'd0;
         `REG6_CFG_OFS, `REG6_RD_OFS, `REG6_WR_OFS: decode_index = 2'd1;
         `REG7_CFG_OFS, `REG7_RD_OFS, `REG7_WR_OFS: decode_index = 2'd2;
         default:                                   decode_index = 2'd3;
      endcase
   endfunction

   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      merge_sel = res;
   endfunction

   // --------------------------------------------------------------------
   // Field helpers
   // --------------------------------------------------------------------
   function automatic logic [3:0] perm_write(input logic [3:0] old_v,
                                             input logic [3:0] new_v,
                                             input logic [3:0] wmask);
      perm_write = (new_v & wmask) | (old_v & ~wmask);
   endfunction

   function automatic logic [31:0] cfg_base(input logic [31:0] cfg);
      cfg_base = {cfg[`CFG_BASE_HI_MSB:`CFG_BASE_HI_LSB],
                  cfg[`CFG_BASE_LO_MSB:`CFG_BASE_LO_LSB], 10'h000};
   endfunction

   function automatic logic [4:0] cfg_size(input logic [31:0] cfg);
      cfg_size = cfg[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
   endfunction

   function automatic logic cfg_pri(input logic [31:0] cfg);
      cfg_pri = cfg[`CFG_PRI_BIT];
   endfunction

   // --------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------
   logic [31:0] cfg_ff  [NUM_REGIONS];
   logic [3:0]  rd_ff   [NUM_REGIONS];
   logic [3:0]  wr_ff   [NUM_REGIONS];
   bus_state_t  bus_state_ff;

   reg_kind_t   req_kind;
   logic [1:0]  req_idx;
   logic        req_new;
   logic        wr_take;

   // --------------------------------------------------------------------
   // Request decode
   // --------------------------------------------------------------------
   assign req_kind = decode_kind(i_wb_adr);
   assign req_idx  = decode_index(i_wb_adr);
   assign req_new  = i_wb_cyc && i_wb_stb && (bus_state_ff == BUS_IDLE);
   assign wr_take  = req_new && i_wb_we && (req_kind != KIND_NONE);

   // --------------------------------------------------------------------
   // Register write
   // --------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g++) begin : g_region
         logic [31:0] nxt_cfg;
         logic        cfg_we;
         logic        rd_we;
         logic        wr_we;
         assign nxt_cfg = merge_sel(cfg_ff[g], i_wb_dat, i_wb_sel)
                          & `CFG_IMPL_MASK;
         assign cfg_we = wr_take && req_kind == KIND_CFG && req_idx == 2'(g);
         assign rd_we  = wr_take && req_kind == KIND_RD && req_idx == 2'(g)
                         && i_wb_sel[0];
         assign wr_we  = wr_take && req_kind == KIND_WR && req_idx == 2'(g)
                         && i_wb_sel[0];

         always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
               cfg_ff[g] <= CFG_PRESET & `CFG_IMPL_MASK;
            end else if (cfg_we) begin
               cfg_ff[g] <= nxt_cfg;
            end
         end

         always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
               rd_ff[g] <= RD_PRESET;
            end else if (rd_we) begin
               rd_ff[g] <= perm_write(rd_ff[g], i_wb_dat[3:0],
                                      RD_WR_MASK);
            end
         end

         always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
               wr_ff[g] <= WR_PRESET;
            end else if (wr_we) begin
               wr_ff[g] <= perm_write(wr_ff[g], i_wb_dat[3:0],
                                      WR_WR_MASK);
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------------
   // Read mux
   // --------------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      unique case (req_kind)
         KIND_CFG: rd_mux = cfg_ff[req_idx] & `CFG_IMPL_MASK;
         KIND_RD:  rd_mux = {28'h000_0000, rd_ff[req_idx]};
         KIND_WR:  rd_mux = {28'h000_0000, wr_ff[req_idx]};
         KIND_NONE: rd_mux = 32'h0000_0000;
      endcase
   end

   // --------------------------------------------------------------------
   // Bus state
   // --------------------------------------------------------------------
   bus_state_t  nxt_bus_state;

   always_comb begin
      unique case (bus_state_ff)
         BUS_IDLE: nxt_bus_state = req_new ? BUS_ACK : BUS_IDLE;
         BUS_ACK:  nxt_bus_state = BUS_IDLE;
         default:  nxt_bus_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         bus_state_ff <= BUS_IDLE;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // --------------------------------------------------------------------
   // Bus answer
   // --------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= req_new && (req_kind != KIND_NONE);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_err <= 1'b0;
      end else begin
         o_wb_err <= req_new && (req_kind == KIND_NONE);
      end
   end

   // --------------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (req_new && !i_wb_we) begin
         o_wb_dat <= rd_mux;
      end
   end

   // --------------------------------------------------------------------
   // Region match and permission check
   // --------------------------------------------------------------------
   // Base is address bits 31:10; size n spans 2^(n+1) bytes, min 4 bytes at n = 1, size 0 matches nothing
   function automatic logic region_match(input logic [31:0] cfg,
                                         input logic [31:0] addr);
      logic [31:0] mask;
      mask = ~((32'h0000_0002 << cfg_size(cfg)) - 32'h0000_0001);
      if (cfg_size(cfg) == 5'h00) begin
         region_match = 1'b0;
      end else begin
         region_match = ((addr & mask) == (cfg_base(cfg) & mask));
      end
   endfunction

   logic [NUM_REGIONS-1:0] hit_vec;
   logic [NUM_REGIONS-1:0] pri_vec;

   generate
      for (g = 0; g < NUM_REGIONS; g++) begin : g_match
         // Addresses arrive physical from every initiator
         assign hit_vec[g] = region_match(cfg_ff[g], i_acc_phys_addr);
         assign pri_vec[g] = cfg_pri(cfg_ff[g]);
      end
   endgenerate

   logic       nxt_hit;
   logic [1:0] nxt_region;
   logic       nxt_allow;

   // --------------------------------------------------------------------
   // Priority select
   // --------------------------------------------------------------------
   // High-priority hits win, then the highest region number
   always_comb begin
      nxt_hit    = 1'b0;
      nxt_region = 2'd0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
         if (hit_vec[r] && !pri_vec[r]) begin
            nxt_hit    = 1'b1;
            nxt_region = 2'(r);
         end
      end
      for (int r = 0; r < NUM_REGIONS; r++) begin
         if (hit_vec[r] && pri_vec[r]) begin
            nxt_hit    = 1'b1;
            nxt_region = 2'(r);
         end
      end
      nxt_allow = i_acc_write ? wr_ff[nxt_region][i_acc_group]
                              : rd_ff[nxt_region][i_acc_group];
   end

   // --------------------------------------------------------------------
   // Verdict outputs
   // --------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_acc_hit <= 1'b0;
      end else begin
         o_acc_hit <= i_acc_valid && nxt_hit;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_acc_grant <= 1'b0;
      end else begin
         o_acc_grant <= i_acc_valid && nxt_hit && nxt_allow;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_acc_bus_err <= 1'b0;
      end else begin
         o_acc_bus_err <= i_acc_valid && nxt_hit && !nxt_allow;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_acc_region <= 2'd0;
      end else begin
         o_acc_region <= nxt_region;
      end
   end

endmodule // region_perm

// ---- pkg/region_perm_regs.svh ----
// Register offsets, field positions, reset presets and masks for the regions
`ifndef REGION_PERM_REGS_SVH
`define REGION_PERM_REGS_SVH

// -----------------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------------
`define REG5_CFG_OFS      16'h84E0
`define REG5_RD_OFS       16'h84F0
`define REG5_WR_OFS       16'h84F8
`define REG6_CFG_OFS      16'h8500
`define REG6_RD_OFS       16'h8510
`define REG6_WR_OFS       16'h8518
`define REG7_CFG_OFS      16'h8520
`define REG7_RD_OFS       16'h8530
`define REG7_WR_OFS       16'h8538
`define REG8_CFG_OFS      16'h8540
`define REG8_RD_OFS       16'h8550
`define REG8_WR_OFS       16'h8558

// -----------------------------------------------------------------------
// Configuration field positions
// -----------------------------------------------------------------------
`define CFG_BASE_HI_MSB   31
`define CFG_BASE_HI_LSB   16
`define CFG_BASE_LO_MSB   15
`define CFG_BASE_LO_LSB   10
`define CFG_PRI_BIT       9
`define CFG_SIZE_MSB      7
`define CFG_SIZE_LSB      3
`define CFG_IMPL_MASK     32'hFFFF_FEF8
`define PERM_IMPL_MASK    32'h0000_000F

// -----------------------------------------------------------------------
// Reset presets
// -----------------------------------------------------------------------
`define CFG_RESET         32'h0000_0000
`define RD_PERM_RESET     4'h7
`define WR_PERM_RESET     4'h7
`define PERM_WR_MASK      4'hF

`endif

// ---- pkg/region_perm_pkg.sv ----
// Types for the region permission block
package region_perm_pkg;

   typedef enum logic [1:0] {
      KIND_CFG  = 2'b00,
      KIND_RD   = 2'b01,
      KIND_WR   = 2'b10,
      KIND_NONE = 2'b11
   } reg_kind_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;

endpackage

// ---- verification/region_perm_checker.sv ----
// Bus and verdict assertions for the region permission block
`timescale 1ns/1ps
`include "region_perm_regs.svh"
module region_perm_checker (
   // Clock, reset and register bus
   input wire logic        i_core_clk,
   input wire logic        i_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [15:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        o_wb_err,
   // Access check
   input wire logic        i_acc_valid,
   input wire logic        o_acc_hit,
   input wire logic        o_acc_grant,
   input wire logic        o_acc_bus_err
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic take;
   logic cfg_adr;
   logic perm_adr;
   assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
   assign cfg_adr = i_wb_adr inside {`REG5_CFG_OFS, `REG6_CFG_OFS,
      `REG7_CFG_OFS, `REG8_CFG_OFS};
   assign perm_adr = i_wb_adr inside {`REG5_RD_OFS, `REG5_WR_OFS,
      `REG6_RD_OFS, `REG6_WR_OFS, `REG7_RD_OFS, `REG7_WR_OFS,
      `REG8_RD_OFS, `REG8_WR_OFS};
   property p_mapped; take && (cfg_adr || perm_adr) |=> o_wb_ack && !o_wb_err;
   endproperty
   property p_unmapped;
      take && !(cfg_adr || perm_adr) |=> o_wb_err && !o_wb_ack;
   endproperty
   property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
   property p_cfg_zero;
      take && !i_wb_we && cfg_adr |=> (o_wb_dat & ~(`CFG_IMPL_MASK)) == 32'h0;
   endproperty
   property p_perm_zero;
      take && !i_wb_we && perm_adr |=> o_wb_dat[31:4] == 28'h0;
   endproperty
   property p_hit_cause; o_acc_hit |-> $past(i_acc_valid); endproperty
   property p_verdict; o_acc_hit == (o_acc_grant | o_acc_bus_err); endproperty
   property p_exclusive; !(o_acc_grant && o_acc_bus_err); endproperty
   a_mapped: assert property (p_mapped)
      else $error("no ack for mapped register");
   a_unmapped: assert property (p_unmapped)
      else $error("no error for unmapped address");
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   a_cfg_zero: assert property (p_cfg_zero)
      else $error("config spare bits not zero");
   a_perm_zero: assert property (p_perm_zero)
      else $error("permission upper bits not zero");
   a_hit_cause: assert property (p_hit_cause)
      else $error("hit without request");
   a_verdict: assert property (p_verdict)
      else $error("hit without verdict");
   a_exclusive: assert property (p_exclusive)
      else $error("grant and bus error together");
   c_write: cover property (take && i_wb_we);
   c_err: cover property (o_wb_err);
   c_grant: cover property (o_acc_grant);
   c_refuse: cover property (o_acc_bus_err);
endmodule // region_perm_checker

// ---- verification/bus_initiator_model.sv ----
// Bus initiator model issuing access checks on physical addresses
`timescale 1ns/1ps
module bus_initiator_model (
   // Clock
   input  wire logic   i_core_clk,
   // Access request
   output logic        o_acc_valid,
   output logic [31:0] o_acc_phys_addr,
   output logic        o_acc_write,
   output logic [1:0]  o_acc_group
);
   initial begin
      o_acc_valid = 1'b0;
      o_acc_phys_addr = 32'h0000_0000;
      o_acc_write = 1'b0;
      o_acc_group = 2'h0;
   end
   // Address is already physical, no translation
   task automatic issue(input logic [31:0] addr, input logic wr,
                        input logic [1:0] grp);
      @(posedge i_core_clk);
      o_acc_valid <= 1'b1;
      o_acc_phys_addr <= addr;
      o_acc_write <= wr;
      o_acc_group <= grp;
      @(posedge i_core_clk);
      o_acc_valid <= 1'b0;
      o_acc_phys_addr <= ~addr;
      o_acc_write <= ~wr;
      o_acc_group <= ~grp;
   endtask
endmodule // bus_initiator_model

// ---- verification/tb_region_perm.sv ----
// Self-checking bench for the region permission block
`timescale 1ns/1ps
`include "region_perm_regs.svh"
module tb_region_perm;
   logic        clk, rst, cyc, stb, we, ack, werr, av, aw, hit, gnt, berr;
   logic [15:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, aadr, rv;
   logic [1:0]  agrp, reg_o;
   logic        re;
   int          err_total, compares, cyc_cnt, g;
   logic [15:0] b;
   region_perm u_region_perm (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(werr),
      .i_acc_valid(av), .i_acc_phys_addr(aadr), .i_acc_write(aw),
      .i_acc_group(agrp), .o_acc_hit(hit), .o_acc_grant(gnt),
      .o_acc_bus_err(berr), .o_acc_region(reg_o));
   bus_initiator_model u_bus_initiator_model (.i_core_clk(clk),
      .o_acc_valid(av), .o_acc_phys_addr(aadr), .o_acc_write(aw),
      .o_acc_group(agrp));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic wrap_up;
      if (err_total == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 2000) begin
         err_total++;
         wrap_up;
      end
   end
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", nm, exp, got);
         err_total++;
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge clk iff (ack | werr));
      rv = rdat;
      re = werr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), exp, rv);
   endtask
   task automatic acc(logic [31:0] a, logic w, logic [1:0] gp, logic [4:0] e);
      u_bus_initiator_model.issue(a, w, gp);
      #1;
      chk("verdict", {27'h0, e}, {27'h0, hit, gnt, berr, reg_o});
   endtask
   initial begin
      {rst, cyc, stb, we, adr, sel, wdat} = {3'b100, 53'h0};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(`REG5_CFG_OFS, `CFG_RESET);
      rd(`REG5_WR_OFS, 32'h0000_0007);
      for (g = 0; g < 4; g++) begin
         b = 16'h84E0 + 16'(g * 32);
         wb(1'b1, b, 32'hFFFF_FFFF);
         rd(b, 32'hFFFF_FEF8);
         wb(1'b1, b + 16'h0010, 32'hFFFF_FFFF);
         rd(b + 16'h0010, 32'h0000_000F);
         wb(1'b1, b + 16'h0018, 32'hFFFF_FFFF);
         rd(b + 16'h0018, 32'h0000_000F);
         wb(1'b1, b, 32'h0000_0000);
      end
      wb(1'b1, 16'h84E4, 32'h1234_5678);
      chk("err", 32'h1, {31'h0, re});
      wb(1'b1, `REG5_CFG_OFS, 32'h0001_0048);
      wb(1'b1, `REG5_RD_OFS, 32'h0000_0005);
      wb(1'b1, `REG5_WR_OFS, 32'h0000_000A);
      for (g = 0; g < 4; g++) begin
         acc(32'h0001_0010, 1'b0, 2'(g),
             {1'b1, !g[0], g[0], 2'd0});
         acc(32'h0001_03FC, 1'b1, 2'(g),
             {1'b1, g[0], !g[0], 2'd0});
      end
      acc(32'h0001_0400, 1'b0, 2'd0, 5'h00);
      wb(1'b1, `REG8_CFG_OFS, 32'h0001_0248);
      acc(32'h0001_0010, 1'b1, 2'd0, {3'b110, 2'd3});
      wrap_up;
   end
endmodule // tb_region_perm
bind region_perm region_perm_checker u_chk (.i_core_clk(i_core_clk),
   .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
   .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .i_acc_valid(i_acc_valid),
   .o_acc_hit(o_acc_hit), .o_acc_grant(o_acc_grant),
   .o_acc_bus_err(o_acc_bus_err));
